// ---- ptc_tick_counter.sv ----
// Periodic tick counter: prescaler, 8-bit match counter and Wishbone register slave
//
// Summary of operation
// - Count is readable; bus writes to the count register do nothing.
// - Count clears on reset, limit write, or changed source/divider write.
// - Match limit is a full 8-bit read/write byte, zero after reset.
// - Limit zero sets the flag on every prescaler output tick.
// - Any limit write clears prescaler and count, whatever the value.
// - After reset count is zero, limit zero, prescaler off.
// - Reset selects the low-power oscillator as the source.
// - Prescaler idles while divider code is zero, runs otherwise.
// - Source 00 low-power, 01 external, 1x internal reference.
// - Divider code and source low bit choose the ratio together.
// - Source low bit 0 ratios: 8..1024, then 1,2,4,10,16,100,500,1000.
// - Writing a different source clears prescaler and count.
// - Writing a different divider code clears prescaler and count.
// - Count steps once per tick up to the limit, then wraps.
// - Flag sets when the count goes from the limit to zero.
// - Interrupt request is flag AND enable; otherwise software polls.
// - Writing one to the flag clears it and its request.
// - Writing zero leaves the flag; reset clears flag, enable, selections.
`timescale 1ns/1ps
module ptc_tick_counter
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Source clocks from outside this domain
    input  wire logic        low_power_osc_clock_i,
    input  wire logic        external_ref_clock_i,
    input  wire logic        internal_ref_clock_i,
    // Interrupt request
    output logic             match_irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]             tick_count_reg,  tick_count_next;
    logic [7:0]             match_limit_reg, match_limit_next;
    logic [1:0]             source_select_reg, source_select_next;
    logic [3:0]             divider_select_reg, divider_select_next;
    logic                   match_irq_enable_reg, match_irq_enable_next;
    logic                   match_flag_reg, match_flag_next;
    logic [PTC_PRESC_W-1:0] presc_reg, presc_next;
    logic [31:0]            dat_next;
    logic                   ack_next;
    logic                   irq_next;
    logic                   src_edge;
    logic                   take;
    logic                   wr_byte;
    logic                   wr_ctrl;
    logic                   wr_count;
    logic                   wr_limit;
    logic                   cfg_clear;
    logic                   tick;
    logic [PTC_PRESC_W-1:0] ratio;

    // ------------------------------------------------------------------
    // Source synchronisation and edge pulse
    // ------------------------------------------------------------------
    ptc_source_edge u_source_edge (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .src_clk_i       ({internal_ref_clock_i, external_ref_clock_i,
                           low_power_osc_clock_i}),
        .source_select_i (source_select_reg),
        .src_edge_o      (src_edge)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Request is taken once; ack blocks a second take of the same cycle
    always_comb begin
        take     = cyc_i & stb_i & ~ack_o;
        wr_byte  = take & we_i & sel_i[0];
        wr_ctrl  = 1'b0;
        wr_count = 1'b0;
        wr_limit = 1'b0;
        if (adr_i[3:2] == PTC_IDX_STATUS_CONTROL)
            wr_ctrl = wr_byte;
        else if (adr_i[3:2] == PTC_IDX_TICK_COUNT)
            wr_count = wr_byte;
        else if (adr_i[3:2] == PTC_IDX_MATCH_LIMIT)
            wr_limit = wr_byte;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        match_limit_next      = match_limit_reg;
        source_select_next    = source_select_reg;
        divider_select_next   = divider_select_reg;
        match_irq_enable_next = match_irq_enable_reg;
        if (wr_limit)
            match_limit_next = dat_i[7:0];
        if (wr_ctrl) begin
            source_select_next    = dat_i[PTC_BIT_SRC_HI:PTC_BIT_SRC_LO];
            divider_select_next   = dat_i[PTC_BIT_DIV_HI:PTC_BIT_DIV_LO];
            match_irq_enable_next = dat_i[PTC_BIT_MATCH_IRQ_ENABLE];
        end
        // Besides a limit write, only a changed selection restarts the count, so enable writes are harmless
        cfg_clear = wr_limit
                  | (wr_ctrl & (dat_i[PTC_BIT_SRC_HI:PTC_BIT_SRC_LO]
                                != source_select_reg))
                  | (wr_ctrl & (dat_i[PTC_BIT_DIV_HI:PTC_BIT_DIV_LO]
                                != divider_select_reg));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_limit_reg      <= PTC_RST_LIMIT;
            source_select_reg    <= PTC_RST_SOURCE;
            divider_select_reg   <= PTC_RST_DIV;
            match_irq_enable_reg <= 1'b0;
        end else begin
            match_limit_reg      <= match_limit_next;
            source_select_reg    <= source_select_next;
            divider_select_reg   <= divider_select_next;
            match_irq_enable_reg <= match_irq_enable_next;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // Tick on the last source edge of each divide period
    always_comb begin
        ratio      = ptc_divide_ratio(source_select_reg[0],
                                      divider_select_reg);
        tick       = src_edge & (divider_select_reg != PTC_RST_DIV)
                   & (presc_reg == ratio - 18'h0_0001);
        presc_next = presc_reg;
        if (cfg_clear || divider_select_reg == PTC_RST_DIV || tick)
            presc_next = '0;
        else if (src_edge)
            presc_next = presc_reg + 18'h0_0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            presc_reg <= '0;
        else
            presc_reg <= presc_next;
    end

    // ------------------------------------------------------------------
    // Counter and match flag
    // ------------------------------------------------------------------
    // A clear from software wins over a tick in the same cycle for the count
    always_comb begin
        tick_count_next = tick_count_reg;
        if (cfg_clear)
            tick_count_next = PTC_RST_COUNT;
        else if (tick && tick_count_reg == match_limit_reg)
            tick_count_next = PTC_RST_COUNT;
        else if (tick)
            tick_count_next = tick_count_reg + 8'h01;
        match_flag_next = match_flag_reg;
        if (wr_ctrl && dat_i[PTC_BIT_MATCH_FLAG])
            match_flag_next = 1'b0;
        // Setting beats clearing so no wrap is lost
        if (!cfg_clear && tick && tick_count_reg == match_limit_reg)
            match_flag_next = 1'b1;
        irq_next = match_flag_next & match_irq_enable_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_count_reg <= PTC_RST_COUNT;
            match_flag_reg <= 1'b0;
            match_irq_o    <= 1'b0;
        end else begin
            tick_count_reg <= tick_count_next;
            match_flag_reg <= match_flag_next;
            match_irq_o    <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    // Unmapped words answer with zero data rather than an error
    always_comb begin
        ack_next = take;
        dat_next = dat_o;
        if (take) begin
            dat_next = 32'h0000_0000;
            if (adr_i[3:2] == PTC_IDX_STATUS_CONTROL)
                dat_next[7:0] = {match_flag_reg, source_select_reg,
                                 match_irq_enable_reg, divider_select_reg};
            else if (adr_i[3:2] == PTC_IDX_TICK_COUNT)
                dat_next[7:0] = tick_count_reg;
            else if (adr_i[3:2] == PTC_IDX_MATCH_LIMIT)
                dat_next[7:0] = match_limit_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= ack_next;
            dat_o <= dat_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wrap;
        tick && !cfg_clear && tick_count_reg == match_limit_reg;
    endsequence

    sequence s_limit_write;
        wr_limit;
    endsequence

    // A control write restarts the count only when a selection really changes
    sequence s_src_change;
        wr_ctrl && dat_i[PTC_BIT_SRC_HI:PTC_BIT_SRC_LO] != source_select_reg;
    endsequence

    sequence s_div_change;
        wr_ctrl && dat_i[PTC_BIT_DIV_HI:PTC_BIT_DIV_LO] != divider_select_reg;
    endsequence

    // Counter, flag and prescaler
    a_count_wrap: assert property (s_wrap |=> tick_count_reg == 8'h00 && match_flag_reg)
        else $error("wrap did not zero count and set flag");
    a_count_step: assert property (tick && !cfg_clear
        && tick_count_reg != match_limit_reg
        |=> tick_count_reg == $past(tick_count_reg) + 8'h01)
        else $error("count did not step by one");
    a_count_hold: assert property (!tick && !cfg_clear |=> $stable(tick_count_reg))
        else $error("count moved without a tick");
    a_zero_limit: assert property (tick && !cfg_clear && match_limit_reg == 8'h00
        |=> match_flag_reg)
        else $error("zero limit tick did not set the flag");
    a_presc_off: assert property (divider_select_reg == 4'h0
        |-> !tick ##1 presc_reg == '0)
        else $error("prescaler ran with divider code zero");

    // Clears caused by software
    a_limit_clears: assert property (s_limit_write |=> tick_count_reg == 8'h00
        && presc_reg == '0 && match_limit_reg == $past(dat_i[7:0]))
        else $error("limit write did not clear count and prescaler");
    a_src_change: assert property (s_src_change
        |=> tick_count_reg == 8'h00 && presc_reg == '0)
        else $error("source change did not clear counters");
    a_div_change: assert property (s_div_change
        |=> tick_count_reg == 8'h00 && presc_reg == '0)
        else $error("divider change did not clear counters");

    // Register side
    a_count_ro: assert property (wr_count && !tick && !cfg_clear
        |=> $stable(tick_count_reg))
        else $error("count register changed by a write");
    a_read_count: assert property (take && !we_i && adr_i[3:2] == PTC_IDX_TICK_COUNT
        |=> ack_o && dat_o[7:0] == $past(tick_count_reg))
        else $error("count read returned a wrong value");
    a_limit_hold: assert property (!wr_limit |=> $stable(match_limit_reg))
        else $error("limit changed without a write");

    // Flag and interrupt
    a_irq_follow: assert property (match_flag_reg && match_irq_enable_reg
        && !wr_ctrl |=> match_irq_o)
        else $error("interrupt missing with flag and enable");
    a_irq_masked: assert property (!match_irq_enable_reg && !wr_ctrl |=> !match_irq_o)
        else $error("interrupt raised while disabled");
    a_flag_clear: assert property (wr_ctrl && dat_i[PTC_BIT_MATCH_FLAG] && !tick
        |=> !match_flag_reg && !match_irq_o)
        else $error("flag not cleared by writing one");
    a_flag_keep: assert property (match_flag_reg && wr_ctrl
        && !dat_i[PTC_BIT_MATCH_FLAG] |=> match_flag_reg)
        else $error("writing zero cleared the flag");

    // Reset state, looked at while reset is applied
    a_reset_state: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> tick_count_reg == 8'h00 && match_limit_reg == 8'h00
        && source_select_reg == PTC_SRC_LOW_POWER && !match_flag_reg)
        else $error("reset state wrong");
    a_reset_sel: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> divider_select_reg == 4'h0 && !match_irq_enable_reg
        && !match_irq_o && !ack_o)
        else $error("reset left selection or outputs set");

endmodule : ptc_tick_counter

// ---- ptc_pkg.sv ----
// Package with register map, field layout, reset values and divide table of the tick counter
package ptc_pkg;

    // ------------------------------------------------------------------
    // Register map (word offsets on the bus)
    // ------------------------------------------------------------------
    localparam logic [1:0] PTC_IDX_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] PTC_IDX_TICK_COUNT     = 2'h1;
    localparam logic [1:0] PTC_IDX_MATCH_LIMIT    = 2'h2;

    // ------------------------------------------------------------------
    // Field layout of the status/control byte
    // ------------------------------------------------------------------
    localparam int PTC_BIT_MATCH_FLAG       = 7;
    localparam int PTC_BIT_SRC_HI           = 6;
    localparam int PTC_BIT_SRC_LO           = 5;
    localparam int PTC_BIT_MATCH_IRQ_ENABLE = 4;
    localparam int PTC_BIT_DIV_HI           = 3;
    localparam int PTC_BIT_DIV_LO           = 0;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] PTC_RST_COUNT  = 8'h00;
    localparam logic [7:0] PTC_RST_LIMIT  = 8'h00;
    localparam logic [1:0] PTC_RST_SOURCE = 2'h0;
    localparam logic [3:0] PTC_RST_DIV    = 4'h0;
    localparam int         PTC_PRESC_W    = 18;
    localparam logic [1:0] PTC_SRC_LOW_POWER = 2'h0;
    localparam logic [1:0] PTC_SRC_EXTERNAL  = 2'h1;

    // ------------------------------------------------------------------
    // Divide ratio from source low bit and divider code
    // ------------------------------------------------------------------
    function automatic logic [PTC_PRESC_W-1:0] ptc_divide_ratio(input logic src_lo,
                                                                input logic [3:0] div);
        logic [PTC_PRESC_W-1:0] r;
        r = 18'h0_0001;
        if (!src_lo) begin
            case (div)
                4'h1:    r = 18'h0_0008;
                4'h2:    r = 18'h0_0020;
                4'h3:    r = 18'h0_0040;
                4'h4:    r = 18'h0_0080;
                4'h5:    r = 18'h0_0100;
                4'h6:    r = 18'h0_0200;
                4'h7:    r = 18'h0_0400;
                4'h8:    r = 18'h0_0001;
                4'h9:    r = 18'h0_0002;
                4'hA:    r = 18'h0_0004;
                4'hB:    r = 18'h0_000A;
                4'hC:    r = 18'h0_0010;
                4'hD:    r = 18'h0_0064;
                4'hE:    r = 18'h0_01F4;
                4'hF:    r = 18'h0_03E8;
                default: r = 18'h0_0001;
            endcase
        end else begin
            case (div)
                4'h1:    r = 18'h0_0400;
                4'h2:    r = 18'h0_0800;
                4'h3:    r = 18'h0_1000;
                4'h4:    r = 18'h0_2000;
                4'h5:    r = 18'h0_4000;
                4'h6:    r = 18'h0_8000;
                4'h7:    r = 18'h1_0000;
                4'h8:    r = 18'h0_03E8;
                4'h9:    r = 18'h0_07D0;
                4'hA:    r = 18'h0_1388;
                4'hB:    r = 18'h0_2710;
                4'hC:    r = 18'h0_4E20;
                4'hD:    r = 18'h0_C350;
                4'hE:    r = 18'h1_86A0;
                4'hF:    r = 18'h3_0D40;
                default: r = 18'h0_0001;
            endcase
        end
        return r;
    endfunction : ptc_divide_ratio

endpackage : ptc_pkg

// ---- ptc_source_edge.sv ----
// Source clock synchronisers, source selector and rising-edge pulse of the tick counter
`timescale 1ns/1ps
module ptc_source_edge
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Raw source clocks: low power, external, internal
    input  wire logic [2:0] src_clk_i,
    // Selection
    input  wire logic [1:0] source_select_i,
    // One-cycle pulse per rising edge of the chosen source
    output logic            src_edge_o
);

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       level;
    logic       prev_reg;
    logic       prev_next;
    logic       edge_next;

    // ------------------------------------------------------------------
    // Two-stage synchroniser per source
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            // First stage feeds only the second stage
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= src_clk_i[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Selector and edge detector
    // ------------------------------------------------------------------
    // Upper select bit alone picks the internal reference
    always_comb begin
        if (source_select_i[1])
            level = sync2_reg[2];
        else if (source_select_i == PTC_SRC_EXTERNAL)
            level = sync2_reg[1];
        else
            level = sync2_reg[0];
        prev_next = level;
        edge_next = level & ~prev_reg;
    end

    // Edge pulse is registered so the counter sees a clean strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg   <= 1'b0;
            src_edge_o <= 1'b0;
        end else begin
            prev_reg   <= prev_next;
            src_edge_o <= edge_next;
        end
    end

endmodule : ptc_source_edge

// ---- ptc_testbench.sv ----
// Self-checking testbench for the periodic tick counter
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t ns: %s got %h expected %h", $time, msg, got, exp); end end
module testbench;
    import ptc_pkg::*;

    // ------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [3:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [2:0]  src_clk;
    logic        match_irq_o;
    int          bad_count;
    int          checked;
    logic [7:0]  rd;

    ptc_tick_counter u_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .cyc_i                 (cyc_i),
        .stb_i                 (stb_i),
        .we_i                  (we_i),
        .adr_i                 (adr_i),
        .sel_i                 (sel_i),
        .dat_i                 (dat_i),
        .dat_o                 (dat_o),
        .ack_o                 (ack_o),
        .low_power_osc_clock_i (src_clk[0]),
        .external_ref_clock_i  (src_clk[1]),
        .internal_ref_clock_i  (src_clk[2]),
        .match_irq_o           (match_irq_o)
    );

    // 25 MHz bus clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Bus and source clock tasks
    // ------------------------------------------------------------------
    // One classic cycle; waits for ack as long as it takes, idles one cycle after
    task automatic wb_xfer(input logic wr, input logic [1:0] idx, input logic [7:0] d,
                           output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        q = dat_o[7:0];
        `CHECK(n, 2, "ack one cycle after take")
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb_xfer

    task automatic wb_write(input logic [1:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask : wb_write

    // Read a register and compare it with the expected byte
    task automatic wb_expect(input logic [1:0] idx, input logic [7:0] exp, input string msg);
        wb_xfer(1'b0, idx, 8'h00, rd);
        `CHECK(rd, exp, msg)
    endtask : wb_expect

    // Rising edges on one source; slow enough for the two-stage synchroniser
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk_i);
            src_clk[which] <= 1'b1;
            repeat (4) @(posedge clk_i);
            src_clk[which] <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_values();
        wb_expect(PTC_IDX_STATUS_CONTROL, 8'h00, "control after reset");
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "count after reset");
        wb_expect(PTC_IDX_MATCH_LIMIT, 8'h00, "limit after reset");
        pulse(0, 3);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "prescaler off");
        wb_write(PTC_IDX_MATCH_LIMIT, 8'hFF);
        wb_expect(PTC_IDX_MATCH_LIMIT, 8'hFF, "limit full byte");
        wb_expect(2'h3, 8'h00, "unmapped word");
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_wrap_flag_irq();
        wb_write(PTC_IDX_MATCH_LIMIT, 8'h03);
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h18); // Low power source, divide by 1, irq on
        pulse(0, 3);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h03, "count at limit");
        `CHECK(match_irq_o, 1'b0, "irq before match")
        wb_write(PTC_IDX_TICK_COUNT, 8'h55);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h03, "count write ignored");
        pulse(0, 1);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "count wrapped");
        wb_expect(PTC_IDX_STATUS_CONTROL, 8'h98, "flag at wrap");
        `CHECK(match_irq_o, 1'b1, "irq with flag")
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h18);
        wb_expect(PTC_IDX_STATUS_CONTROL, 8'h98, "zero leaves flag");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h08);
        repeat (2) @(posedge clk_i);
        `CHECK(match_irq_o, 1'b0, "irq masked")
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h98);
        wb_expect(PTC_IDX_STATUS_CONTROL, 8'h18, "flag cleared");
        `CHECK(match_irq_o, 1'b0, "irq cleared")
        $display("test wrap_flag_irq done");
    endtask : test_wrap_flag_irq

    task automatic test_limit_zero();
        wb_write(PTC_IDX_MATCH_LIMIT, 8'h00);
        repeat (2) begin
            pulse(0, 1);
            wb_expect(PTC_IDX_STATUS_CONTROL, 8'h98, "flag every tick");
            wb_write(PTC_IDX_STATUS_CONTROL, 8'h98);
        end
        $display("test limit_zero done");
    endtask : test_limit_zero

    task automatic test_clears_and_sources();
        wb_write(PTC_IDX_MATCH_LIMIT, 8'h0A);
        pulse(0, 5);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h05, "count five");
        wb_write(PTC_IDX_MATCH_LIMIT, 8'h0A);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "limit write clears");
        pulse(0, 2);
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h18);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h02, "same selection keeps");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h19);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "divider change clears");
        pulse(0, 3);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h01, "divide by two");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h11);
        pulse(0, 7);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "divide by eight early");
        pulse(0, 1);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h01, "divide by eight");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h31);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "source change clears");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h38);
        pulse(0, 4);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "low power not used");
        pulse(1, 999);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "ratio 1000 early");
        pulse(1, 1);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h01, "ratio 1000");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h48);
        pulse(2, 1);
        pulse(1, 2);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h01, "internal source");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h68);
        pulse(2, 1000);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h01, "source 11 internal");
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h40);
        pulse(2, 3);
        wb_expect(PTC_IDX_TICK_COUNT, 8'h00, "divider zero off");
        $display("test clears_and_sources done");
    endtask : test_clears_and_sources

    // Reset in mid-run with the flag and interrupt up
    task automatic test_mid_reset();
        wb_write(PTC_IDX_MATCH_LIMIT, 8'h00);
        wb_write(PTC_IDX_STATUS_CONTROL, 8'h58);
        pulse(2, 1);
        `CHECK(match_irq_o, 1'b1, "irq before reset")
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_expect(PTC_IDX_STATUS_CONTROL, 8'h00, "control reset");
        wb_expect(PTC_IDX_MATCH_LIMIT, 8'h00, "limit reset");
        `CHECK(match_irq_o, 1'b0, "irq reset")
        $display("test mid_reset done");
    endtask : test_mid_reset

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // About 17k cycles expected; allow several times that
    initial begin
        #3_000_000;
        bad_count++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        bad_count = 0;
        checked   = 0;
        rst_i     = 1'b1;
        cyc_i     = 1'b0;
        stb_i     = 1'b0;
        we_i      = 1'b0;
        adr_i     = 4'h0;
        sel_i     = 4'hF;
        dat_i     = 32'h0000_0000;
        src_clk   = 3'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_wrap_flag_irq();
        test_limit_zero();
        test_clears_and_sources();
        test_mid_reset();
        report_and_stop();
    end

endmodule : testbench
